// ### fwu_pkg.sv
// fwu_pkg: shared constants and types of the firmware-upgrade node controller
// assumes a 100 MHz system clock
package fwu_pkg;

  // upgrade control states
  typedef enum logic [2:0] {
    FWU_IDLE,
    FWU_RECEIVING,
    FWU_COMPLETE,
    FWU_COUNTDOWN,
    FWU_UPGRADE
  } fwu_state_e;

  // decoded request kinds
  typedef enum logic [3:0] {
    FWU_REQ_INIT,
    FWU_REQ_PAGE,
    FWU_REQ_STATE,
    FWU_REQ_INFO,
    FWU_REQ_MISSING,
    FWU_REQ_INTEGRITY,
    FWU_REQ_EXECUTE,
    FWU_REQ_ACCEPT,
    FWU_REQ_ABORT
  } fwu_req_e;

  // reply kinds
  typedef enum logic [2:0] {
    FWU_RSP_NONE,
    FWU_RSP_STATE,
    FWU_RSP_INFO,
    FWU_RSP_MISSING,
    FWU_RSP_INTEGRITY
  } fwu_rsp_e;

  // state report codes
  localparam logic [2:0] FWU_CODE_IDLE = 3'h0;
  localparam logic [2:0] FWU_CODE_RECEIVING = 3'h1;
  localparam logic [2:0] FWU_CODE_COMPLETE = 3'h2;
  localparam logic [2:0] FWU_CODE_COUNTDOWN = 3'h3;
  localparam logic [2:0] FWU_CODE_UPGRADE = 3'h4;

  // page_length field encodings, in bytes
  localparam logic [7:0] FWU_PAGE_LEN_0 = 8'h20;
  localparam logic [7:0] FWU_PAGE_LEN_1 = 8'h40;
  localparam logic [7:0] FWU_PAGE_LEN_2 = 8'h80;
  localparam logic [7:0] FWU_PAGE_LEN_3 = 8'hC0;

  // timer base
  localparam int FWU_CLK_HZ = 100_000_000;
  localparam int FWU_TICK_S = 1;
  localparam int FWU_TICK_CYCLES = FWU_CLK_HZ * FWU_TICK_S;
  localparam int FWU_TIMER_W = 16;

  // register map
  localparam logic [7:0] FWU_REG_CTRL = 8'h00;
  localparam logic [7:0] FWU_REG_STATUS = 8'h04;
  localparam logic [7:0] FWU_REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] FWU_REG_IRQ_ENABLE = 8'h0C;
  localparam logic [7:0] FWU_REG_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] FWU_REG_TIMERS = 8'h14;
  localparam logic [31:0] FWU_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FWU_IRQ_EN_RESET = 32'h0000_0000;

  // interrupt status bits
  localparam int FWU_IRQ_W = 4;
  localparam int FWU_IRQ_REPLY = 0;
  localparam int FWU_IRQ_ACCEPTED = 1;
  localparam int FWU_IRQ_REJECTED = 2;
  localparam int FWU_IRQ_RESTART = 3;

  // ctrl register fields
  localparam int FWU_CTRL_ENABLE = 0;

  // page length decode, used by core for o_page_bytes; status readback shows the raw two-bit code
  function automatic logic [7:0] fwu_page_bytes(input logic [1:0] code);
    unique case (code)
      2'd0: fwu_page_bytes = FWU_PAGE_LEN_0;
      2'd1: fwu_page_bytes = FWU_PAGE_LEN_1;
      2'd2: fwu_page_bytes = FWU_PAGE_LEN_2;
      2'd3: fwu_page_bytes = FWU_PAGE_LEN_3;
    endcase
  endfunction : fwu_page_bytes

endpackage : fwu_pkg

// ### fwu_sec_timer.sv
// fwu_sec_timer: down counter in whole seconds with a one-cycle expiry pulse
// assumes a shared one-second tick on the same clock
`timescale 1ns/1ps
`default_nettype none
module fwu_sec_timer #(
  parameter int WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  input wire logic i_stop,
  output logic o_running,
  output logic o_expired
);
  logic [WIDTH-1:0] count_q;
  logic run_q;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_q <= '0;
      run_q <= 1'b0;
    end else if (i_load) begin
      count_q <= i_value;
      run_q <= (i_value != '0);
    end else if (i_stop) begin
      run_q <= 1'b0;
    end else if (run_q && i_tick) begin
      count_q <= count_q - 1'b1;
      if (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= run_q && i_tick && !i_load && !i_stop
                   && (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  assign o_running = run_q;

  a_expiry_one_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_expired |=> !o_expired) else $error("expiry pulse longer than one cycle");
  a_expiry_stops_run: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_expired |-> !run_q || $past(i_load)) else $error("timer still running after expiry");

endmodule : fwu_sec_timer
`default_nettype wire

// ### fwu_ahb_regs.sv
// fwu_ahb_regs: AHB-Lite slave holding control, status and interrupt registers
// assumes a single master, word transfers, zero wait states
`timescale 1ns/1ps
`default_nettype none
module fwu_ahb_regs
  import fwu_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_timers_word,
  input wire logic [fwu_pkg::FWU_IRQ_W-1:0] i_irq_event,
  output logic [31:0] o_ctrl,
  output logic o_irq
);
  logic wr_q;
  logic [7:0] addr_q;
  logic [FWU_IRQ_W-1:0] irq_st_q;
  logic [FWU_IRQ_W-1:0] irq_en_q;
  logic [FWU_IRQ_W-1:0] clr_mask;
  logic take;

  // hsize ignored: only whole words are mapped
  assign take = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take && i_hwrite;
      if (take) begin
        addr_q <= i_haddr[7:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctrl <= FWU_CTRL_RESET;
      irq_en_q <= FWU_IRQ_EN_RESET[FWU_IRQ_W-1:0];
    end else if (wr_q) begin
      if (addr_q == FWU_REG_CTRL) o_ctrl <= i_hwdata;
      if (addr_q == FWU_REG_IRQ_ENABLE) irq_en_q <= i_hwdata[FWU_IRQ_W-1:0];
    end
  end

  assign clr_mask = (wr_q && addr_q == FWU_REG_IRQ_CLEAR) ? i_hwdata[FWU_IRQ_W-1:0] : '0;

  // a new event beats a clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~clr_mask) | i_irq_event;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (take && !i_hwrite) begin
      unique case (i_haddr[7:0])
        FWU_REG_CTRL: o_hrdata <= o_ctrl;
        FWU_REG_STATUS: o_hrdata <= i_status_word;
        FWU_REG_IRQ_STATUS: o_hrdata <= {{(32-FWU_IRQ_W){1'b0}}, irq_st_q};
        FWU_REG_IRQ_ENABLE: o_hrdata <= {{(32-FWU_IRQ_W){1'b0}}, irq_en_q};
        FWU_REG_TIMERS: o_hrdata <= i_timers_word;
        default: o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_irq = |(irq_st_q & irq_en_q);

endmodule : fwu_ahb_regs
`default_nettype wire

// ### fwu_node_ctrl.sv
// fwu_node_ctrl: firmware-upgrade control state machine of an end node
// assumes requests arrive decoded, one per strobe, on the system clock
`timescale 1ns/1ps
`default_nettype none
// How it works
// - control sits in exactly one of idle, receiving, complete, countdown, upgrade.
// - complete answers most queries with code 2, info with info reply, drops pages.
// - init request in idle moves to receiving, reporting code 1.
// - idle answers queries with code 0, info with info reply, drops pages.
// - receiving moves to complete silently once image whole and integrity good.
// - receiving takes pages, answers missing queries, integrity queries once image whole, others code 1.
// - abort in receiving, complete or countdown reports code 0, goes idle.
// - execute in complete goes countdown code 3, or upgrade code 4 if zero delay.
// - execute nonzero in countdown reloads restart timer and stores trial period, code 3; expiry enters upgrade.
// - execute zero in countdown reloads timers, code 4, enters upgrade at once.
// - upgrade reports code 4 to queries, drops pages; execute gets code 0.
// - accept, abort or trial expiry in upgrade report code 0 and return idle.
// - trial expiry or abort rejects new image; accept discards old one.
// - two-bit page_length field codes 32, 64, 128, 192 bytes.
module fwu_node_ctrl
  import fwu_pkg::*;
#(
  parameter int TICK_CYCLES = fwu_pkg::FWU_TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // request strobe with its decoded fields
  input wire logic i_req_valid,
  input wire fwu_pkg::fwu_req_e i_req_kind,
  input wire logic [1:0] i_page_length,
  input wire logic [fwu_pkg::FWU_TIMER_W-1:0] i_restart_delay,
  input wire logic [fwu_pkg::FWU_TIMER_W-1:0] i_trial_period,
  // image store status
  input wire logic i_image_whole,
  input wire logic i_integrity_ok,
  // reply strobe
  output logic o_rsp_valid,
  output fwu_pkg::fwu_rsp_e o_rsp_kind,
  output logic [2:0] o_rsp_code,
  // image control
  output logic [1:0] o_state_code_dummy_unused,
  output logic o_page_accept,
  output logic [7:0] o_page_bytes,
  output logic o_drop_image,
  output logic o_restart_new,
  output logic o_keep_new,
  output logic o_reject_new,
  output logic o_running,
  // AHB-Lite register port
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_irq
);
  fwu_state_e state_q, state_d;
  fwu_rsp_e rsp_kind_d;
  logic [2:0] rsp_code_d;
  logic rsp_d;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic restart_load, trial_load, trial_stop, restart_stop;
  logic restart_run, trial_run, restart_exp, trial_exp;
  logic [1:0] page_code_q;
  logic [31:0] ctrl;
  logic enable;
  logic accepted, rejected, entering_upgrade;
  logic [FWU_TIMER_W-1:0] trial_hold_q;
  logic [FWU_IRQ_W-1:0] irq_event;
  logic req;
  logic exec_zero;

  assign enable = ctrl[FWU_CTRL_ENABLE];
  // software enable gates the request path so a node can be fenced off
  assign req = i_req_valid && enable;
  assign exec_zero = (i_restart_delay == '0);

  // one-second tick shared by both timers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
    end
  end
  assign tick = (tick_cnt_q == TICK_CYCLES - 1);

  // next state and reply decode
  always_comb begin
    state_d = state_q;
    rsp_d = 1'b0;
    rsp_kind_d = FWU_RSP_NONE;
    rsp_code_d = FWU_CODE_IDLE;
    if (req && i_req_kind == FWU_REQ_INFO) begin
      rsp_d = 1'b1;
      rsp_kind_d = FWU_RSP_INFO;
    end else begin
      unique case (state_q)
        FWU_IDLE: begin
          if (req && i_req_kind != FWU_REQ_PAGE) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            if (i_req_kind == FWU_REQ_INIT) begin
              rsp_code_d = FWU_CODE_RECEIVING;
              state_d = FWU_RECEIVING;
            end else begin
              rsp_code_d = FWU_CODE_IDLE;
            end
          end
        end
        FWU_RECEIVING: begin
          if (req && i_req_kind != FWU_REQ_PAGE) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            rsp_code_d = FWU_CODE_RECEIVING;
            if (i_req_kind == FWU_REQ_ABORT) begin
              rsp_code_d = FWU_CODE_IDLE;
              state_d = FWU_IDLE;
            end else if (i_req_kind == FWU_REQ_MISSING) begin
              rsp_kind_d = FWU_RSP_MISSING;
            end else if (i_req_kind == FWU_REQ_INTEGRITY && i_image_whole) begin
              rsp_kind_d = FWU_RSP_INTEGRITY;
            end
          end else if (i_image_whole && i_integrity_ok) begin
            state_d = FWU_COMPLETE;
          end
        end
        FWU_COMPLETE: begin
          if (req && i_req_kind != FWU_REQ_PAGE) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            rsp_code_d = FWU_CODE_COMPLETE;
            if (i_req_kind == FWU_REQ_ABORT) begin
              rsp_code_d = FWU_CODE_IDLE;
              state_d = FWU_IDLE;
            end else if (i_req_kind == FWU_REQ_EXECUTE) begin
              rsp_code_d = exec_zero ? FWU_CODE_UPGRADE : FWU_CODE_COUNTDOWN;
              state_d = exec_zero ? FWU_UPGRADE : FWU_COUNTDOWN;
            end
          end
        end
        FWU_COUNTDOWN: begin
          if (req && i_req_kind != FWU_REQ_PAGE) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            rsp_code_d = FWU_CODE_COUNTDOWN;
            if (i_req_kind == FWU_REQ_ABORT) begin
              rsp_code_d = FWU_CODE_IDLE;
              state_d = FWU_IDLE;
            end else if (i_req_kind == FWU_REQ_EXECUTE && exec_zero) begin
              rsp_code_d = FWU_CODE_UPGRADE;
              state_d = FWU_UPGRADE;
            end
          end else if (restart_exp) begin
            state_d = FWU_UPGRADE;
          end
        end
        FWU_UPGRADE: begin
          if (req && i_req_kind != FWU_REQ_PAGE) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            rsp_code_d = FWU_CODE_UPGRADE;
            if (i_req_kind == FWU_REQ_EXECUTE) begin
              rsp_code_d = FWU_CODE_IDLE;
            end else if (i_req_kind == FWU_REQ_ACCEPT || i_req_kind == FWU_REQ_ABORT) begin
              rsp_code_d = FWU_CODE_IDLE;
              state_d = FWU_IDLE;
            end
          end else if (trial_exp) begin
            rsp_d = 1'b1;
            rsp_kind_d = FWU_RSP_STATE;
            rsp_code_d = FWU_CODE_IDLE;
            state_d = FWU_IDLE;
          end
        end
      endcase
    end
    // an expiry that shares its cycle with a request is kept, unless the request is abort or an execute that reloads the restart timer
    if (state_q == FWU_COUNTDOWN && state_d == FWU_COUNTDOWN && restart_exp && !restart_load) begin
      state_d = FWU_UPGRADE;
    end
    if (state_q == FWU_UPGRADE && state_d == FWU_UPGRADE && trial_exp) begin
      rsp_d = 1'b1;
      rsp_kind_d = FWU_RSP_STATE;
      rsp_code_d = FWU_CODE_IDLE;
      state_d = FWU_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= FWU_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_kind <= FWU_RSP_NONE;
      o_rsp_code <= FWU_CODE_IDLE;
    end else begin
      o_rsp_valid <= rsp_d;
      // kind and code stay readable until the next reply
      if (rsp_d) begin
        o_rsp_kind <= rsp_kind_d;
        o_rsp_code <= rsp_code_d;
      end
    end
  end

  // page length latched on init, held for the whole download
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_code_q <= 2'd0;
    end else if (state_q == FWU_IDLE && req && i_req_kind == FWU_REQ_INIT) begin
      page_code_q <= i_page_length;
    end
  end
  assign o_page_bytes = fwu_page_bytes(page_code_q);

  assign o_page_accept = req && i_req_kind == FWU_REQ_PAGE && state_q == FWU_RECEIVING;
  // integrity failure empties the store so pages are fetched again
  assign o_drop_image = state_q == FWU_RECEIVING && i_image_whole && !i_integrity_ok
                        && req && i_req_kind == FWU_REQ_INTEGRITY;

  // execute stores the trial period; it only starts on entering upgrade
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trial_hold_q <= '0;
    end else if (req && i_req_kind == FWU_REQ_EXECUTE
                 && (state_q == FWU_COMPLETE || state_q == FWU_COUNTDOWN)) begin
      trial_hold_q <= i_trial_period;
    end
  end

  assign restart_load = req && i_req_kind == FWU_REQ_EXECUTE
                        && (state_q == FWU_COMPLETE || state_q == FWU_COUNTDOWN);
  assign restart_stop = state_q != FWU_COUNTDOWN && state_d != FWU_COUNTDOWN;
  assign entering_upgrade = state_q != FWU_UPGRADE && state_d == FWU_UPGRADE;
  assign trial_load = entering_upgrade;
  assign trial_stop = state_q == FWU_UPGRADE && state_d != FWU_UPGRADE;

  fwu_sec_timer #(
    .WIDTH(FWU_TIMER_W)
  ) u_restart_timer (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_load(restart_load),
    .i_value(i_restart_delay),
    .i_stop(restart_stop),
    .o_running(restart_run),
    .o_expired(restart_exp)
  );

  fwu_sec_timer #(
    .WIDTH(FWU_TIMER_W)
  ) u_trial_timer (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_load(trial_load),
    .i_value(restart_load ? i_trial_period : trial_hold_q),
    .i_stop(trial_stop),
    .o_running(trial_run),
    .o_expired(trial_exp)
  );

  assign accepted = state_q == FWU_UPGRADE && req && i_req_kind == FWU_REQ_ACCEPT && !trial_exp;
  assign rejected = state_q == FWU_UPGRADE && state_d == FWU_IDLE && !accepted;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_keep_new <= 1'b0;
      o_reject_new <= 1'b0;
      o_restart_new <= 1'b0;
    end else begin
      o_keep_new <= accepted;
      o_reject_new <= rejected;
      o_restart_new <= entering_upgrade;
    end
  end

  assign o_running = state_q != FWU_IDLE;
  assign o_state_code_dummy_unused = 2'b00;
  assign irq_event = {o_restart_new, o_reject_new, o_keep_new, o_rsp_valid};

  fwu_ahb_regs u_regs (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .i_status_word({21'h00_0000, page_code_q, trial_run, restart_run, 4'h0, 3'(state_q)}),
    .i_timers_word({trial_hold_q, 13'h0000, o_rsp_code}),
    .i_irq_event(irq_event),
    .o_ctrl(ctrl),
    .o_irq(o_irq)
  );

  a_init_to_recv: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_IDLE && req && i_req_kind == FWU_REQ_INIT
    |=> state_q == FWU_RECEIVING && o_rsp_valid && o_rsp_code == FWU_CODE_RECEIVING)
    else $error("init in idle did not enter receiving with code 1");
  a_idle_code_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_IDLE && req && !(i_req_kind inside {FWU_REQ_INIT, FWU_REQ_PAGE, FWU_REQ_INFO})
    |=> o_rsp_code == FWU_CODE_IDLE && state_q == FWU_IDLE)
    else $error("idle reply code not zero");
  a_complete_code: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_COMPLETE && req && i_req_kind inside {FWU_REQ_STATE, FWU_REQ_INIT, FWU_REQ_ACCEPT}
    |=> o_rsp_code == FWU_CODE_COMPLETE && state_q == FWU_COMPLETE)
    else $error("complete reply code not two");
  a_recv_to_complete: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_RECEIVING && !req && i_image_whole && i_integrity_ok
    |=> state_q == FWU_COMPLETE && !o_rsp_valid)
    else $error("receiving did not complete silently");
  a_abort_to_idle: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q inside {FWU_RECEIVING, FWU_COMPLETE, FWU_COUNTDOWN} && req && i_req_kind == FWU_REQ_ABORT
    |=> state_q == FWU_IDLE && o_rsp_code == FWU_CODE_IDLE)
    else $error("abort did not return to idle");
  a_exec_from_complete: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_COMPLETE && req && i_req_kind == FWU_REQ_EXECUTE
    |=> o_rsp_code == ($past(exec_zero) ? FWU_CODE_UPGRADE : FWU_CODE_COUNTDOWN))
    else $error("execute in complete gave wrong code");
  a_countdown_expiry: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_COUNTDOWN && restart_exp && !req |=> state_q == FWU_UPGRADE)
    else $error("restart delay expiry missed");
  a_exec_zero_upg: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_COUNTDOWN && req && i_req_kind == FWU_REQ_EXECUTE && exec_zero
    |=> state_q == FWU_UPGRADE && (trial_run || $past(i_trial_period) == '0))
    else $error("zero-delay execute did not enter upgrade");
  a_upgrade_exec: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_UPGRADE && req && i_req_kind == FWU_REQ_EXECUTE
    |=> state_q == FWU_UPGRADE && o_rsp_code == FWU_CODE_IDLE)
    else $error("execute in upgrade mishandled");
  a_trial_reject: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    state_q == FWU_UPGRADE && trial_exp && !req
    |=> state_q == FWU_IDLE && o_reject_new && !o_keep_new)
    else $error("trial expiry did not reject");

endmodule : fwu_node_ctrl
`default_nettype wire

// ### fwu_head_end.sv
// fwu_head_end: head-end model issuing one-cycle upgrade requests
// assumes the node takes a request on the edge after it is raised
`timescale 1ns/1ps
`default_nettype none
module fwu_head_end
  import fwu_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_req_valid,
  output fwu_pkg::fwu_req_e o_req_kind,
  output logic [1:0] o_page_length,
  output logic [15:0] o_restart_delay,
  output logic [15:0] o_trial_period
);
  initial begin
    o_req_valid = 1'b0;
    o_req_kind = FWU_REQ_STATE;
    o_page_length = 2'h0;
    o_restart_delay = 16'h0000;
    o_trial_period = 16'h0000;
  end
  task automatic send(input fwu_req_e k, input logic [15:0] d, input logic [15:0] t, input logic [1:0] p);
    @(posedge i_sys_clk);
    o_req_valid <= 1'b1;
    o_req_kind <= k;
    o_restart_delay <= d;
    o_trial_period <= t;
    o_page_length <= p;
    @(posedge i_sys_clk);
    o_req_valid <= 1'b0;
    // stale fields must not look valid
    o_restart_delay <= ~d;
    o_trial_period <= ~t;
  endtask : send
endmodule : fwu_head_end
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench of the upgrade node controller
// assumes the head-end model drives requests; this bench is the AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fwu_pkg::*;
  logic i_sys_clk, i_arst_n, hsel, hwrite, whole, ok, rv, irq, hro, rqv;
  logic [1:0] htrans, pl;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0] rc;
  logic [7:0] pb;
  logic [15:0] dly, tp;
  fwu_rsp_e rk;
  fwu_req_e rqk;
  int err_total, cmp_count, cyc;
  logic [31:0] seed = 32'hc886_c0bc;
  logic [7:0] len [4] = '{8'h20, 8'h40, 8'h80, 8'hc0};
  fwu_req_e pool [3] = '{FWU_REQ_STATE, FWU_REQ_INFO, FWU_REQ_PAGE};
  fwu_req_e idl [6] = '{FWU_REQ_STATE, FWU_REQ_MISSING, FWU_REQ_INTEGRITY, FWU_REQ_EXECUTE, FWU_REQ_ACCEPT,
                        FWU_REQ_ABORT};
  fwu_req_e cpl [5] = '{FWU_REQ_STATE, FWU_REQ_MISSING, FWU_REQ_INTEGRITY, FWU_REQ_INIT, FWU_REQ_ACCEPT};
  fwu_head_end hd (.i_sys_clk(i_sys_clk), .o_req_valid(rqv), .o_req_kind(rqk), .o_page_length(pl),
    .o_restart_delay(dly), .o_trial_period(tp));
  // short tick keeps second-based timers to tens of cycles
  fwu_node_ctrl #(.TICK_CYCLES(10)) u_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req_valid(rqv),
    .i_req_kind(rqk), .i_page_length(pl), .i_restart_delay(dly), .i_trial_period(tp), .i_image_whole(whole),
    .i_integrity_ok(ok), .o_rsp_valid(rv), .o_rsp_kind(rk), .o_rsp_code(rc), .o_state_code_dummy_unused(),
    .o_page_accept(), .o_page_bytes(pb), .o_drop_image(), .o_restart_new(), .o_keep_new(), .o_reject_new(),
    .o_running(), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hro), .o_hreadyout(hro), .o_hresp(), .o_hrdata(hrdata), .o_irq(irq));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic fwu_rsp_e ek(input fwu_req_e k);
    return k == FWU_REQ_INFO ? FWU_RSP_INFO : (k == FWU_REQ_PAGE ? FWU_RSP_NONE : FWU_RSP_STATE);
  endfunction : ek
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge i_sys_clk); while (hro !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_sys_clk); while (hro !== 1'b1);
    rd = hrdata;
    #1;
  endtask : ahb
  task automatic q(input fwu_req_e k, input logic [2:0] c, input logic [15:0] d = 16'h0000,
                   input logic [15:0] t = 16'h0000, input logic [1:0] p = 2'h0);
    hd.send(k, d, t, p);
    #1;
    chk(rv, ek(k) != FWU_RSP_NONE);
    if (ek(k) != FWU_RSP_NONE) chk(rk, ek(k));
    if (ek(k) == FWU_RSP_STATE) chk(rc, c);
  endtask : q
  task automatic fill(input logic [1:0] p);
    q(FWU_REQ_INIT, FWU_CODE_RECEIVING, 16'h0000, 16'h0000, p);
    ahb(1'b0, FWU_REG_STATUS, 32'h0000_0000);
    chk(rd[10:9], p);
    chk(pb, len[p]);
    q(FWU_REQ_INTEGRITY, FWU_CODE_RECEIVING);
    q(FWU_REQ_EXECUTE, FWU_CODE_RECEIVING);
    whole = 1'b1;
    hd.send(FWU_REQ_INTEGRITY, 16'h0000, 16'h0000, 2'h0);
    #1;
    chk(rk, FWU_RSP_INTEGRITY);
    ok = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk(rv, 1'b0);
    whole = 1'b0;
    ok = 1'b0;
    foreach (cpl[i]) q(cpl[i], FWU_CODE_COMPLETE);
    repeat (4) q(pool[xs() % 3], FWU_CODE_COMPLETE);
  endtask : fill
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {i_arst_n, hsel, hwrite, whole, ok, htrans, haddr, hwdata} = '0;
    repeat (4) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    ahb(1'b0, FWU_REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, FWU_REG_CTRL, 32'h0000_0001);
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    foreach (idl[i]) q(idl[i], FWU_CODE_IDLE);
    repeat (6) q(pool[xs() % 3], FWU_CODE_IDLE);
    ahb(1'b0, FWU_REG_IRQ_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b1);
    chk(irq, 1'b0);
    ahb(1'b1, FWU_REG_IRQ_ENABLE, 32'h0000_0001);
    chk(irq, 1'b1);
    ahb(1'b1, FWU_REG_IRQ_CLEAR, 32'h0000_000f);
    chk(irq, 1'b0);
    ahb(1'b1, FWU_REG_IRQ_ENABLE, 32'h0000_0000);
    fill(2'(xs()));
    q(FWU_REQ_EXECUTE, FWU_CODE_COUNTDOWN, 16'h0002);
    q(FWU_REQ_STATE, FWU_CODE_COUNTDOWN);
    repeat (40) @(posedge i_sys_clk);
    ahb(1'b0, FWU_REG_STATUS, 32'h0000_0000);
    chk(rd[2:0], 3'h4);
    q(FWU_REQ_MISSING, FWU_CODE_UPGRADE);
    q(FWU_REQ_EXECUTE, FWU_CODE_IDLE);
    q(FWU_REQ_ACCEPT, FWU_CODE_IDLE);
    ahb(1'b0, FWU_REG_STATUS, 32'h0000_0000);
    chk(rd[2:0], 3'h0);
    fill(2'(xs()));
    q(FWU_REQ_EXECUTE, FWU_CODE_COUNTDOWN, 16'h0005, 16'h0002);
    q(FWU_REQ_EXECUTE, FWU_CODE_UPGRADE, 16'h0000, 16'h0002);
    ahb(1'b0, FWU_REG_TIMERS, 32'h0000_0000);
    chk(rd, 32'h0002_0004);
    @(posedge i_sys_clk);
    #1;
    repeat (100) if (rv !== 1'b1) @(posedge i_sys_clk) #1;
    chk(rv, 1'b1);
    chk(rc, FWU_CODE_IDLE);
    ahb(1'b0, FWU_REG_IRQ_STATUS, 32'h0000_0000);
    chk(rd[3:2], 2'h3);
    fill(2'(xs()));
    q(FWU_REQ_ABORT, FWU_CODE_IDLE);
    q(FWU_REQ_INIT, FWU_CODE_RECEIVING);
    q(FWU_REQ_ABORT, FWU_CODE_IDLE);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
